// ---- hdl/dcdi_nco.sv ----
// phase accumulator that emits one toggle pulse per output half period
// assumes step and limit come from logic on the same clock
`timescale 1ns/10ps
module dcdi_nco
  import dcdi_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                rstn_i,
  input  wire logic                en_i,
  input  wire logic [STEP_W-1:0]   step_i,
  input  wire logic [ACC_W-1:0]    limit_i,
  output logic                     tick_o
);

  // ****************************************
  // accumulator
  // ****************************************
  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic [ACC_W:0]   sum;
  logic             wrap;

  assign sum     = {1'b0, acc_ff} + {{(ACC_W+1-STEP_W){1'b0}}, step_i};
  assign wrap    = sum >= {1'b0, limit_i};
  assign nxt_acc = wrap ? ACC_W'(sum - {1'b0, limit_i}) : sum[ACC_W-1:0];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_ff <= '0;
      tick_o <= 1'b0;
    end else if (en_i) begin
      acc_ff <= nxt_acc;
      tick_o <= wrap;
    end else begin
      acc_ff <= '0;
      tick_o <= 1'b0;
    end
  end

endmodule

// ---- hdl/dcdi_pkg.sv ----
// package for the dual core deep idle clock block
// assumes one 50 mhz system clock and a reference clock sampled as a pin
package dcdi_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ  = 50_000_000;
  localparam int unsigned LOCK_TIME_US = 35;
  localparam int unsigned LOCK_CYCLES  = (LOCK_TIME_US * CLK_FREQ_HZ) / 1_000_000;
  localparam int unsigned LOCK_W       = 11;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned PERIOD_W = 16;
  localparam int unsigned STEP_W   = 6;
  localparam int unsigned ACC_W    = PERIOD_W + 1;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hffff;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [3:0]          FACTOR_MIN = 4'h1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic {MODE_BYPASS, MODE_MULT} dcdi_mode_e;

  typedef enum logic [1:0] {ST_OFF, ST_LOCKING, ST_LOCKED} dcdi_lock_e;

  typedef struct packed {
    logic [3:0] int_part;
    logic [1:0] quarter;
  } dcdi_factor_s;

  typedef struct packed {
    logic a_deep_idle;
    logic b_deep_idle;
  } dcdi_idle_s;

endpackage

// ---- hdl/dcdi_top.sv ----
// clock control: deep idle gating of the shared generator and the machine clock
// assumes idle pulses, wake, mode and factor come from logic on clock_i;
// the reference clock is a pin and is synchronised here
//
// Function
// - power down only when both subsystems idle
// - both idle switches generator off automatically
// - arrival order of idle requests is irrelevant
// - multiply mode scales reference by N 1..15
// - quarter, half, three quarter fractions supported
// - lock phase up to 35 us after change
// - bypass passes reference period straight through
`timescale 1ns/10ps
module dcdi_top
  import dcdi_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  input  wire logic         reference_clock_input_i,
  input  wire dcdi_mode_e   mode_i,
  input  wire dcdi_factor_s factor_i,
  input  wire dcdi_idle_s   deep_idle_instruction_i,
  input  wire logic         wake_i,
  output logic              machine_clock_output_o,
  output logic              locked_o,
  output logic              sub_a_clk_en_o,
  output logic              sub_b_clk_en_o,
  output logic              gen_off_o
);

  // ****************************************
  // reference synchroniser and edge detect
  // ****************************************
  logic ref_meta_ff;
  logic ref_sync_ff;
  logic ref_last_ff;
  logic ref_rise;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_meta_ff <= 1'b0;
      ref_sync_ff <= 1'b0;
      ref_last_ff <= 1'b0;
    end else begin
      ref_meta_ff <= reference_clock_input_i;
      ref_sync_ff <= ref_meta_ff;
      ref_last_ff <= ref_sync_ff;
    end
  end

  assign ref_rise = ref_sync_ff & ~ref_last_ff;

  // ****************************************
  // deep idle tracking
  // ****************************************
  logic a_idle_ff;
  logic b_idle_ff;
  logic nxt_a_idle;
  logic nxt_b_idle;
  logic both_idle;

  assign nxt_a_idle = deep_idle_instruction_i.a_deep_idle | (a_idle_ff & ~wake_i);
  assign nxt_b_idle = deep_idle_instruction_i.b_deep_idle | (b_idle_ff & ~wake_i);
  assign both_idle  = a_idle_ff & b_idle_ff;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_idle_ff <= 1'b0;
      b_idle_ff <= 1'b0;
    end else begin
      a_idle_ff <= nxt_a_idle;
      b_idle_ff <= nxt_b_idle;
    end
  end

  // ****************************************
  // clock enables and generator shutdown
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sub_a_clk_en_o <= 1'b1;
      sub_b_clk_en_o <= 1'b1;
      gen_off_o      <= 1'b0;
    end else begin
      sub_a_clk_en_o <= ~a_idle_ff;
      sub_b_clk_en_o <= ~b_idle_ff;
      gen_off_o      <= both_idle;
    end
  end

  // ****************************************
  // reference period measurement
  // ****************************************
  logic [PERIOD_W-1:0] cnt_ff;
  logic [PERIOD_W-1:0] period_ff;
  logic [PERIOD_W-1:0] nxt_cnt;
  logic [PERIOD_W-1:0] cnt_sat;

  // saturate so a slow reference never stores a zero period
  assign cnt_sat = (cnt_ff == PERIOD_MAX) ? cnt_ff : PERIOD_W'(cnt_ff + 1'b1);
  assign nxt_cnt = ref_rise ? PERIOD_RST : cnt_sat;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff    <= PERIOD_RST;
      period_ff <= PERIOD_RST;
    end else if (!gen_off_o) begin
      cnt_ff <= nxt_cnt;
      if (ref_rise) begin
        period_ff <= cnt_sat;
      end
    end
  end

  // ****************************************
  // multiplier factor
  // ****************************************
  logic [3:0]        int_clamped;
  logic [STEP_W-1:0] step;
  logic [ACC_W-1:0]  limit;

  assign int_clamped = (factor_i.int_part < FACTOR_MIN) ? FACTOR_MIN : factor_i.int_part;
  assign step        = {int_clamped, factor_i.quarter};
  assign limit       = {period_ff, 1'b0};

  // ****************************************
  // lock sequencing
  // ****************************************
  dcdi_lock_e          lock_st_ff;
  dcdi_lock_e          nxt_lock_st;
  logic [LOCK_W-1:0]   lock_cnt_ff;
  dcdi_factor_s        factor_last_ff;
  dcdi_mode_e          mode_last_ff;
  logic                restart;
  logic                lock_done;

  assign restart   = (factor_i != factor_last_ff) | (mode_i != mode_last_ff);
  assign lock_done = lock_cnt_ff == LOCK_LAST;

  always_comb begin
    nxt_lock_st = lock_st_ff;
    case (lock_st_ff)
      ST_OFF: begin
        if (!gen_off_o) begin
          nxt_lock_st = ST_LOCKING;
        end
      end
      ST_LOCKING: begin
        if (gen_off_o) begin
          nxt_lock_st = ST_OFF;
        end else if (lock_done && !restart) begin
          nxt_lock_st = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (gen_off_o) begin
          nxt_lock_st = ST_OFF;
        end else if (restart) begin
          nxt_lock_st = ST_LOCKING;
        end
      end
      default: begin
        nxt_lock_st = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_st_ff     <= ST_OFF;
      lock_cnt_ff    <= '0;
      factor_last_ff <= '0;
      mode_last_ff   <= MODE_BYPASS;
    end else begin
      lock_st_ff     <= nxt_lock_st;
      factor_last_ff <= factor_i;
      mode_last_ff   <= mode_i;
      if (nxt_lock_st != ST_LOCKING || restart) begin
        lock_cnt_ff <= '0;
      end else if (!lock_done) begin
        lock_cnt_ff <= LOCK_W'(lock_cnt_ff + 1'b1);
      end
    end
  end

  // ****************************************
  // multiplied clock generation
  // ****************************************
  logic mult_run;
  logic tick;
  logic mult_clk_ff;

  assign mult_run = (lock_st_ff == ST_LOCKED) && (mode_i == MODE_MULT)
                  && (period_ff != PERIOD_RST);

  dcdi_nco u_nco (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .en_i    (mult_run),
    .step_i  (step),
    .limit_i (limit),
    .tick_o  (tick)
  );

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mult_clk_ff <= 1'b0;
    end else if (!mult_run) begin
      mult_clk_ff <= 1'b0;
    end else if (tick) begin
      mult_clk_ff <= ~mult_clk_ff;
    end
  end

  // ****************************************
  // output selection
  // ****************************************
  logic bypass_sel;
  logic nxt_mclk;
  logic nxt_locked;

  assign bypass_sel = mode_i == MODE_BYPASS;
  assign nxt_mclk   = gen_off_o  ? 1'b0
                    : bypass_sel ? ref_sync_ff : mult_clk_ff;
  assign nxt_locked = ~gen_off_o & (bypass_sel | (lock_st_ff == ST_LOCKED));

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      machine_clock_output_o <= 1'b0;
      locked_o               <= 1'b0;
    end else begin
      machine_clock_output_o <= nxt_mclk;
      locked_o               <= nxt_locked;
    end
  end

endmodule

// ---- verification/dcdi_ref_osc.sv ----
// free running reference oscillator
// assumes nothing; phase unrelated to the system clock
`timescale 1ns/10ps
module dcdi_ref_osc #(
  parameter real HALF_NS = 800.0
) (
  output logic ref_o
);
  initial begin
    ref_o = 1'b0;
    #7.3;
    forever #(HALF_NS) ref_o = ~ref_o;
  end
endmodule

// ---- verification/dcdi_sva.sv ----
// checker on the ports of dcdi_top
// assumes one clock domain and async low reset
`timescale 1ns/10ps
module dcdi_sva
  import dcdi_pkg::*;
(
  input wire logic         clock_i,
  input wire logic         rstn_i,
  input wire logic         reference_clock_input_i,
  input wire dcdi_mode_e   mode_i,
  input wire dcdi_factor_s factor_i,
  input wire dcdi_idle_s   deep_idle_instruction_i,
  input wire logic         wake_i,
  input wire logic         machine_clock_output_o,
  input wire logic         locked_o,
  input wire logic         sub_a_clk_en_o,
  input wire logic         sub_b_clk_en_o,
  input wire logic         gen_off_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic [11:0] lo_ff;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) lo_ff <= 12'h000;
    else lo_ff <= (!locked_o && mode_i == MODE_MULT && !gen_off_o) ? lo_ff + 12'h001 : 12'h000;
  end
  sequence s_a; deep_idle_instruction_i.a_deep_idle && !wake_i; endsequence
  sequence s_b; deep_idle_instruction_i.b_deep_idle && !wake_i; endsequence
  sequence s_wake; wake_i && deep_idle_instruction_i == 2'h0; endsequence
  property p_idle_a; s_a |-> ##2 !sub_a_clk_en_o; endproperty
  property p_idle_b; s_b |-> ##2 !sub_b_clk_en_o; endproperty
  property p_both; gen_off_o == (!sub_a_clk_en_o && !sub_b_clk_en_o); endproperty
  property p_other; $fell(sub_b_clk_en_o) |-> $past(deep_idle_instruction_i.b_deep_idle, 2);
  endproperty
  property p_wake; s_wake |-> ##2 (sub_a_clk_en_o && sub_b_clk_en_o && !gen_off_o); endproperty
  property p_off; gen_off_o ##1 gen_off_o |-> !machine_clock_output_o && !locked_o; endproperty
  property p_drop; mode_i == MODE_MULT && $changed(factor_i) |-> ##2 !locked_o; endproperty
  property p_lock; lo_ff <= 12'h6e0; endproperty
  property p_byp; (mode_i == MODE_BYPASS && !gen_off_o) [*6]
    |-> machine_clock_output_o == $past(reference_clock_input_i, 3); endproperty
  a_idle_a: assert property (p_idle_a) else $error("a clock not stopped");
  a_idle_b: assert property (p_idle_b) else $error("b clock not stopped");
  a_both: assert property (p_both) else $error("generator state wrong");
  a_other: assert property (p_other) else $error("b clock stopped early");
  a_wake: assert property (p_wake) else $error("wake not restored");
  a_off: assert property (p_off) else $error("clock runs while off");
  a_drop: assert property (p_drop) else $error("lock kept on change");
  a_lock: assert property (p_lock) else $error("lock phase too long");
  a_byp: assert property (p_byp) else $error("bypass output wrong");
endmodule
bind dcdi_top dcdi_sva u_sva (.clock_i(clock_i), .rstn_i(rstn_i),
  .reference_clock_input_i(reference_clock_input_i), .mode_i(mode_i), .factor_i(factor_i),
  .deep_idle_instruction_i(deep_idle_instruction_i), .wake_i(wake_i),
  .machine_clock_output_o(machine_clock_output_o), .locked_o(locked_o),
  .sub_a_clk_en_o(sub_a_clk_en_o), .sub_b_clk_en_o(sub_b_clk_en_o), .gen_off_o(gen_off_o));

// ---- verification/test_dual_core_deep_idle_clock.sv ----
// self-checking bench for dcdi_top
// assumes an 80 cycle reference period from dcdi_ref_osc
`timescale 1ns/10ps
module test_dual_core_deep_idle_clock;
  import dcdi_pkg::*;
  logic clock_i, rstn_i, ref_w, wake_i, mclk, locked, en_a, en_b, goff;
  dcdi_mode_e   mode_i;
  dcdi_factor_s factor_i;
  dcdi_idle_s   idle_i;
  int n_mismatch = 0, n_tests = 0, seed = 32'h00f4, ma, mb, c, m;
  int fa[5] = '{4, 10, 13, 19, 60};
  dcdi_ref_osc #(.HALF_NS(800.0)) u_osc (.ref_o(ref_w));
  dcdi_top DUT (.clock_i(clock_i), .rstn_i(rstn_i), .reference_clock_input_i(ref_w),
    .mode_i(mode_i), .factor_i(factor_i), .deep_idle_instruction_i(idle_i), .wake_i(wake_i),
    .machine_clock_output_o(mclk), .locked_o(locked), .sub_a_clk_en_o(en_a),
    .sub_b_clk_en_o(en_b), .gen_off_o(goff));
  // ****
  // tasks
  // ****
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cmp_model;
    check({29'h0, en_a, en_b, goff}, {29'h0, ma == 0, mb == 0, ma && mb});
  endtask
  task idle(input logic a, input logic b);
    @(negedge clock_i);
    idle_i = {a, b};
    @(negedge clock_i);
    idle_i = 2'h0;
    ma = ma | a;
    mb = mb | b;
    repeat (2) @(negedge clock_i);
  endtask
  task near(input int seen, input int exp);
    check(32'(seen * 50 >= exp * 49 - 100 && seen * 50 <= exp * 51 + 100), 32'h1);
  endtask
  task meas(output int cyc);
    int k;
    logic p;
    cyc = 0;
    k = 0;
    p = mclk;
    while (k < 17 && cyc < 20000) begin
      @(negedge clock_i);
      if (k > 0) cyc++;
      if (mclk === 1'b1 && p === 1'b0) k++;
      p = mclk;
    end
  endtask
  // ****
  // stimulus
  // ****
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    test_done();
  end
  initial begin
    rstn_i = 1'b0;
    wake_i = 1'b0;
    idle_i = 2'h0;
    mode_i = MODE_BYPASS;
    factor_i = 6'h04;
    ma = 0;
    mb = 0;
    repeat (3) @(negedge clock_i);
    rstn_i = 1'b1;
    @(negedge clock_i);
    cmp_model(); // reset state
    for (int o = 0; o < 3; o++) begin
      idle(o != 1, o != 0);
      cmp_model(); // first idle: a, then b, then both at once
      idle(o != 0, o != 1);
      cmp_model(); // order free
      repeat (2) @(negedge clock_i);
      check({30'h0, mclk, locked}, 32'h0); // generator off
      @(negedge clock_i);
      wake_i = 1'b1;
      @(negedge clock_i);
      wake_i = 1'b0;
      ma = 0;
      mb = 0;
      repeat (2) @(negedge clock_i);
      cmp_model(); // wake restores
    end
    meas(c);
    near(c, 1280); // bypass period
    mode_i = MODE_MULT;
    for (int i = 0; i < 6; i++) begin
      @(negedge clock_i);
      m = (i < 5) ? fa[i] : 4 + $unsigned($random(seed)) % 56;
      factor_i = 6'(m);
      c = 3;
      repeat (3) @(negedge clock_i);
      while (locked !== 1'b1 && c < 3000) begin
        @(negedge clock_i);
        c++;
      end
      check(32'(c >= LOCK_CYCLES - 4 && c <= LOCK_CYCLES + 6), 32'h1); // lock time
      meas(c);
      near(c, 5120 / m); // rate
    end
    test_done();
  end
endmodule
